// >>> verilog/ssgfm_pkg.sv
package ssgfm_pkg;

   // ==========================================================
   // Configuration store
   localparam int CFG_DEPTH = 253;
   localparam int CFG_WIDTH = 8;
   localparam int CFG_IDX_W = 8;
   localparam logic [7:0] CFG_DEFAULT = 8'h00;
   localparam int CFG_OUT_EN_IDX = 5;
   localparam int CFG_GPIO_BASE_IDX = 224;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 200_000_000;
   localparam int POR_HOLD_MS = 2;
   localparam int STRAP_HOLD_MS = 55;
   localparam int STRAP_HOLD_CYC = STRAP_HOLD_MS * (CLK_HZ / 1000);

   // ==========================================================
   // Pins and function codes
   localparam int NUM_GPIO = 6;
   localparam int NUM_OUT = 8;
   localparam int NUM_REF = 4;
   localparam logic [7:0] STRAP_PIN_MASK = 8'h3B;
   localparam int HPDIFF_PIN = 2;
   localparam logic [6:0] FUNC_PLAIN = 7'h00;
   localparam logic [6:0] FUNC_LOS_BASE = 7'h10;
   localparam logic [6:0] FUNC_LOS_STEP = 7'h04;
   localparam logic [6:0] FUNC_HOST_IRQ = 7'h01;
   localparam logic [1:0] MCLK_20M = 2'h2;
   localparam logic [1:0] MCLK_24M = 2'h3;

   // ==========================================================
   // Register map and fields
   localparam logic [11:0] REG_STATUS = 12'h400;
   localparam logic [11:0] REG_CLEAR = 12'h404;
   localparam logic [11:0] REG_ENABLE = 12'h408;
   localparam logic [11:0] REG_STRAP = 12'h40C;
   localparam int IRQ_W = 6;
   localparam int IRQ_STRAP_BIT = 4;
   localparam int IRQ_LOAD_BIT = 5;
   localparam logic [5:0] IRQ_RST = 6'h00;
   localparam int STRAP_MCLK_LSB = 8;
   localparam int STRAP_RSVD_BIT = 10;
   localparam int STRAP_DONE_BIT = 11;
   localparam int STRAP_READY_BIT = 12;

   typedef enum logic [0:0] {ST_LOAD, ST_RUN} ssgfm_state_type;

endpackage

// >>> verilog/ssgfm_sync.sv
`timescale 1ns/1ps
module ssgfm_sync
   #(parameter int W = 1)
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
   );

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ==========================================================
   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         sync_o <= '0;
      end
      else
      begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
         sync_o <= (s2 & s3) | (sync_o & (s2 ^ s3));
      end
   end

endmodule

// >>> verilog/ssgfm_cfg_store.sv
`timescale 1ns/1ps
module ssgfm_cfg_store
   import ssgfm_pkg::*;
   #(parameter int DEPTH = CFG_DEPTH,
     parameter int WIDTH = CFG_WIDTH)
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [CFG_IDX_W-1:0] wr_idx_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [CFG_IDX_W-1:0] rd_idx_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic [DEPTH*WIDTH-1:0] flat_o
   );

   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH > (1 << CFG_IDX_W) || DEPTH < 1)
   begin : g_chk
      $error("Store depth does not fit the index width");
   end

   // ==========================================================
   // One byte of flip-flops per location
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_loc
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            mem[i] <= WIDTH'(CFG_DEFAULT); // R2
         else if (wr_en_i && wr_idx_i == CFG_IDX_W'(i))
            mem[i] <= wr_data_i; // R7
      end
      assign flat_o[i*WIDTH +: WIDTH] = mem[i];
   end

   // Out-of-range index reads as zero rather than wrapping
   assign rd_data_o = (int'(rd_idx_i) < DEPTH) ? mem[rd_idx_i] : '0;

endmodule

// >>> verilog/ssgfm_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: Board holds reset at least 2 ms
// R2: Reset release starts from default configuration
// R3: Board holds strap pins 55 ms after release
// R4: Straps read, then pins become plain GPIO
// R5: Clock outputs off until configuration enables
// R6: GPIO2 high enables differential output zero
// R7: Configuration store is 253 bytes
// R8: Config from defaults, OTP or host
// R9: Power-up loads OTP contents into store
// R10: Host may rewrite configuration while running
// R11: Pin function from config bits 6:0
// R12: Code zero makes plain input
// R13: Codes 10,14,18,1C are reference LOS inputs
// R14: LOS marks reference failed, raises status
// R15: Host interrupt pin flags status changes
// R16: Pins 1:0 select master clock frequency
// R17: Straps latched once at window end
module ssgfm_top
   import ssgfm_pkg::*;
   #(parameter int NGPIO = NUM_GPIO,
     parameter int NOUT = NUM_OUT,
     parameter int STRAP_CYC = STRAP_HOLD_CYC)
   (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [NGPIO-1:0] GPIO_I,
   output logic [NGPIO-1:0] GPIO_O,
   output logic [NGPIO-1:0] GPIO_OE_O,
   input wire logic OTP_PROG_I,
   input wire logic [7:0] OTP_DATA_I,
   output logic [CFG_IDX_W-1:0] OTP_ADDR_O,
   output logic [NUM_REF-1:0] REF_LOS_O,
   output logic [NOUT-1:0] OUT_EN_O,
   output logic [1:0] MCLK_SEL_O,
   output logic MCLK_RSVD_O,
   output logic [NGPIO-1:0] STRAP_O,
   output logic STRAP_DONE_O,
   output logic CFG_READY_O,
   output logic IRQ_O
   );

   localparam int CNT_W = $clog2(STRAP_CYC + 1);

   if (NGPIO < 6 || NGPIO > 8 || NGPIO > CFG_DEPTH - CFG_GPIO_BASE_IDX || NOUT < 1
       || NOUT > CFG_WIDTH || STRAP_CYC < 1)
   begin : g_chk
      $error("Unsupported pin count, output count or strap window");
   end

   // ==========================================================
   // Decode helpers
   function automatic logic [6:0] gpio_code(input logic [CFG_DEPTH*CFG_WIDTH-1:0] flat,
                                            input int pin);
      gpio_code = flat[(CFG_GPIO_BASE_IDX + pin) * CFG_WIDTH +: 7];
   endfunction

   function automatic logic is_cfg(input logic [11:0] addr);
      is_cfg = int'(addr[11:2]) < CFG_DEPTH;
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = is_cfg(addr) || addr == REG_STATUS || addr == REG_CLEAR
                  || addr == REG_ENABLE || addr == REG_STRAP;
   endfunction

   // ==========================================================
   // Signals
   ssgfm_state_type state;
   logic [CFG_IDX_W-1:0] load_idx;
   logic [NGPIO-1:0] gpio_sync;
   logic [CNT_W-1:0] strap_cnt;
   logic store_wr_en;
   logic [CFG_IDX_W-1:0] store_wr_idx;
   logic [7:0] store_wr_data;
   logic [7:0] store_rd_data;
   logic [CFG_DEPTH*CFG_WIDTH-1:0] cfg_flat;
   logic apb_done;
   logic apb_take;
   logic apb_cfg_wr;
   logic [IRQ_W-1:0] status;
   logic [IRQ_W-1:0] enable;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] clr_mask;
   logic [NGPIO-1:0] pin_active;
   logic [NUM_REF-1:0] next_los;
   logic irq_level;

   // ==========================================================
   // Pin synchroniser and configuration store
   ssgfm_sync #(.W(NGPIO)) u_sync
   (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .async_i(GPIO_I),
      .sync_o(gpio_sync)
   );

   ssgfm_cfg_store u_store
   (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .wr_en_i(store_wr_en),
      .wr_idx_i(store_wr_idx),
      .wr_data_i(store_wr_data),
      .rd_idx_i(PADDR_I[9:2]),
      .rd_data_o(store_rd_data),
      .flat_o(cfg_flat)
   );

   // ==========================================================
   // Power-up load walks every location once
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         state <= ST_LOAD;
         load_idx <= '0;
         CFG_READY_O <= 1'b0;
      end
      else
      begin
         case (state)
            ST_LOAD:
            begin
               if (int'(load_idx) == CFG_DEPTH - 1)
               begin
                  state <= ST_RUN;
                  CFG_READY_O <= 1'b1;
               end
               else
                  load_idx <= load_idx + 1'b1; // R9
            end
            ST_RUN:
               state <= ST_RUN;
            default:
               state <= ST_LOAD;
         endcase
      end
   end

   assign OTP_ADDR_O = load_idx;

   // Unprogrammed OTP falls back to built-in defaults
   always_comb
   begin
      if (state == ST_LOAD)
      begin
         store_wr_en = 1'b1; // R8
         store_wr_idx = load_idx;
         store_wr_data = OTP_PROG_I ? OTP_DATA_I : CFG_DEFAULT; // R9
      end
      else
      begin
         store_wr_en = apb_cfg_wr; // R10
         store_wr_idx = PADDR_I[9:2];
         store_wr_data = PWDATA_I[7:0];
      end
   end

   // ==========================================================
   // APB slave; answers stall until the load is over
   assign apb_done = PSEL_I && PENABLE_I && PREADY_O;
   assign apb_take = PSEL_I && PENABLE_I && !PREADY_O && state == ST_RUN;
   assign apb_cfg_wr = apb_done && PWRITE_I && is_cfg(PADDR_I);
   assign clr_mask = (apb_done && PWRITE_I && PADDR_I == REG_CLEAR) ?
                     PWDATA_I[IRQ_W-1:0] : '0;

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end
      else
      begin
         PREADY_O <= apb_take;
         PSLVERR_O <= apb_take && !is_mapped(PADDR_I);
         PRDATA_O <= 32'h0000_0000;
         if (apb_take && !PWRITE_I)
         begin
            if (is_cfg(PADDR_I))
               PRDATA_O <= {24'h000000, store_rd_data};
            else if (PADDR_I == REG_STATUS)
               PRDATA_O <= {26'h0000000, status};
            else if (PADDR_I == REG_ENABLE)
               PRDATA_O <= {26'h0000000, enable};
            else if (PADDR_I == REG_STRAP)
            begin
               PRDATA_O[NGPIO-1:0] <= STRAP_O;
               PRDATA_O[STRAP_MCLK_LSB +: 2] <= MCLK_SEL_O;
               PRDATA_O[STRAP_RSVD_BIT] <= MCLK_RSVD_O;
               PRDATA_O[STRAP_DONE_BIT] <= STRAP_DONE_O;
               PRDATA_O[STRAP_READY_BIT] <= CFG_READY_O;
            end
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         enable <= IRQ_RST;
      else if (apb_done && PWRITE_I && PADDR_I == REG_ENABLE)
         enable <= PWDATA_I[IRQ_W-1:0];
   end

   // ==========================================================
   // Strap window; pins read once, then released
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         strap_cnt <= '0;
         STRAP_DONE_O <= 1'b0;
         STRAP_O <= '0;
         MCLK_SEL_O <= 2'h0;
         MCLK_RSVD_O <= 1'b0;
      end
      else if (!STRAP_DONE_O)
      begin
         if (int'(strap_cnt) == STRAP_CYC - 1)
         begin
            STRAP_DONE_O <= 1'b1; // R4
            STRAP_O <= gpio_sync & NGPIO'(STRAP_PIN_MASK); // R17 R3
            MCLK_SEL_O <= gpio_sync[1:0]; // R16
            MCLK_RSVD_O <= gpio_sync[1:0] != MCLK_20M && gpio_sync[1:0] != MCLK_24M; // R16
         end
         else
            strap_cnt <= strap_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Pin functions
   // Strap pins get no function until the window closes
   for (genvar p = 0; p < NGPIO; p++)
   begin : g_pin
      assign pin_active[p] = CFG_READY_O && (STRAP_DONE_O || !STRAP_PIN_MASK[p]); // R4
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
         if (RST_I)
         begin
            GPIO_OE_O[p] <= 1'b0;
            GPIO_O[p] <= 1'b0;
         end
         else
         begin
            GPIO_OE_O[p] <= pin_active[p] && gpio_code(cfg_flat, p) == FUNC_HOST_IRQ; // R15 R12
            GPIO_O[p] <= irq_level; // R15
         end
      end
   end

   always_comb
   begin
      next_los = '0;
      for (int r = 0; r < NUM_REF; r++)
      begin
         for (int p = 0; p < NGPIO; p++)
         begin
            if (pin_active[p] && gpio_sync[p]
                && gpio_code(cfg_flat, p) == 7'(FUNC_LOS_BASE + FUNC_LOS_STEP * 7'(r))) // R11 R13
               next_los[r] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         REF_LOS_O <= '0;
      else
         REF_LOS_O <= next_los; // R14
   end

   // ==========================================================
   // Output enables
   // Gate on load end so OTP enables never glitch during the walk
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         OUT_EN_O <= '0; // R5
      else if (!CFG_READY_O)
         OUT_EN_O <= '0; // R5
      else
      begin
         OUT_EN_O <= cfg_flat[CFG_OUT_EN_IDX * CFG_WIDTH +: NOUT];
         if (gpio_sync[HPDIFF_PIN])
            OUT_EN_O[0] <= 1'b1; // R6
      end
   end

   // ==========================================================
   // Interrupt status; a new event beats a same-cycle clear
   assign events[NUM_REF-1:0] = next_los & ~REF_LOS_O; // R14
   assign events[IRQ_STRAP_BIT] = !STRAP_DONE_O && int'(strap_cnt) == STRAP_CYC - 1;
   assign events[IRQ_LOAD_BIT] = state == ST_LOAD && int'(load_idx) == CFG_DEPTH - 1;
   assign irq_level = |(status & enable);

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         status <= IRQ_RST;
         IRQ_O <= 1'b0;
      end
      else
      begin
         status <= (status & ~clr_mask) | events; // R14
         IRQ_O <= irq_level; // R15
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   AST_STRAP_LATCH: assert property ( // R17
      !STRAP_DONE_O && int'(strap_cnt) == STRAP_CYC - 1 |=>
      STRAP_DONE_O && STRAP_O == ($past(gpio_sync) & NGPIO'(STRAP_PIN_MASK)))
      else $error("Straps not latched at window end");
   AST_STRAP_FROZEN: assert property (STRAP_DONE_O ##1 STRAP_DONE_O |-> $stable(STRAP_O)) // R4
      else $error("Strap value changed after latch");
   AST_MCLK: assert property ($rose(STRAP_DONE_O) |-> MCLK_SEL_O == STRAP_O[1:0] // R16
      && MCLK_RSVD_O == !STRAP_O[1])
      else $error("Master clock select mismatch");
   AST_OUT_OFF: assert property (!CFG_READY_O |-> OUT_EN_O == '0) // R5
      else $error("Output enabled before configuration");
   AST_HPDIFF: assert property (CFG_READY_O && gpio_sync[HPDIFF_PIN] |=> OUT_EN_O[0]) // R6
      else $error("Differential output zero not enabled");
   // Release edge skipped: the walk only starts one edge after reset drops
   AST_LOAD_SRC: assert property (state == ST_LOAD && !RST_I |-> store_wr_en // R9
      && store_wr_idx == OTP_ADDR_O ##1 state == ST_RUN || OTP_ADDR_O == $past(OTP_ADDR_O) + 1)
      else $error("Load walk out of step");
   AST_PLAIN: assert property ( // R12
      CFG_READY_O && gpio_code(cfg_flat, 0) == FUNC_PLAIN |=> !GPIO_OE_O[0])
      else $error("Plain input pin driven");
   AST_LOS_FLAG: assert property ($rose(REF_LOS_O[0]) |-> status[0]) // R14
      else $error("Reference loss not flagged");
   AST_LOS_MAP: assert property (pin_active[1] && gpio_sync[1] // R13
      && gpio_code(cfg_flat, 1) == 7'h14 |=> REF_LOS_O[1])
      else $error("Loss code not routed to reference one");
   AST_SET_WINS: assert property (events[IRQ_LOAD_BIT] |=> status[IRQ_LOAD_BIT]) // R14
      else $error("Event lost against clear");
   AST_HOST_IRQ: assert property (pin_active[5] && gpio_code(cfg_flat, 5) == FUNC_HOST_IRQ // R15
      |=> GPIO_OE_O[5] && GPIO_O[5] == $past(irq_level))
      else $error("Host interrupt pin wrong");

   COV_LOAD_DONE: cover property ($rose(CFG_READY_O));
   COV_CFG_WRITE: cover property (apb_cfg_wr);
   COV_LOS: cover property ($rose(REF_LOS_O[0]) ##[1:20] IRQ_O);
   COV_STRAP: cover property ($rose(STRAP_DONE_O));

endmodule

// >>> tb/ssgfm_board_model.sv
`timescale 1ns/1ps
module ssgfm_board_model
   import ssgfm_pkg::*;
   (
   input wire logic strap_done_i,
   input wire logic [5:0] strap_val_i,
   input wire logic [5:0] pin_val_i,
   input wire logic [7:0] otp_addr_i,
   output logic [7:0] otp_data_o,
   output logic [5:0] pin_o
   );
   // ==========================================================
   // Strap drive
   // Straps are held until the device closes its window
   assign pin_o = strap_done_i ? pin_val_i : strap_val_i;
   // ==========================================================
   // Custom OTP contents
   // Output-enable and pin bytes kept zero so outputs stay off
   assign otp_data_o = (otp_addr_i < 8'hE0 && otp_addr_i != 8'h05) ?
                       (otp_addr_i ^ 8'hA5) : 8'h00;
endmodule

// >>> tb/tb_startup_strap_and_gpio_function_map.sv
`timescale 1ns/1ps
module tb_startup_strap_and_gpio_function_map
   import ssgfm_pkg::*;
   ;
   // ==========================================================
   // Signals
   logic clk, rst, psel, penable, pwrite, pready, pslverr, otp_prog;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] gpio_in, gpio_out, gpio_oe, board_pin, strap_val, pin_val, strap;
   logic [7:0] otp_data, otp_addr, out_en;
   logic [3:0] ref_los;
   logic [1:0] mclk_sel;
   logic mclk_rsvd, strap_done, cfg_ready, irq;
   int fails, cmp_count, cycles;

   // Wire level: driven pins win over the board
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_pin);

   ssgfm_top #(.STRAP_CYC(50)) dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .GPIO_I(gpio_in),
      .GPIO_O(gpio_out), .GPIO_OE_O(gpio_oe), .OTP_PROG_I(otp_prog),
      .OTP_DATA_I(otp_data), .OTP_ADDR_O(otp_addr), .REF_LOS_O(ref_los),
      .OUT_EN_O(out_en), .MCLK_SEL_O(mclk_sel), .MCLK_RSVD_O(mclk_rsvd),
      .STRAP_O(strap), .STRAP_DONE_O(strap_done), .CFG_READY_O(cfg_ready),
      .IRQ_O(irq));

   ssgfm_board_model board_u (.strap_done_i(strap_done), .strap_val_i(strap_val),
      .pin_val_i(pin_val), .otp_addr_i(otp_addr), .otp_data_o(otp_data),
      .pin_o(board_pin));

   // ==========================================================
   // Clock and timeout
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Whole run is under two thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         summarize();
      end
   end

   // ==========================================================
   // Tasks
   task automatic summarize();
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; the timeout bounds the wait for ready
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic experr);
      logic [31:0] q;
      logic err;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pslverr", 32'(err), 32'(experr));
      if (!wr)
         check("prdata", q, exp);
   endtask

   task automatic do_reset(input logic prog, input logic [5:0] sv);
      @(posedge clk);
      rst <= 1'b1;
      otp_prog <= prog;
      strap_val <= sv;
      pin_val <= 6'h00;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check("out_en", 32'(out_en), 32'h0);
      while (cfg_ready !== 1'b1)
         @(posedge clk);
      check("out_en", 32'(out_en), 32'h0);
      check("strap", 32'(strap), 32'(sv));
   endtask

   task automatic settle();
      repeat (10) @(posedge clk);
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      otp_prog = 1'b0;
      strap_val = 6'h2A;
      pin_val = 6'h00;
      fails = 0;
      cmp_count = 0;
      cycles = 0;
      do_reset(1'b0, 6'h2A);
      check("mclk", 32'({mclk_rsvd, mclk_sel}), 32'h2);
      acc(0, REG_STRAP, 0, 32'h1A2A, 0);
      acc(0, 12'h000, 0, 32'h0, 0);
      acc(0, 12'h3F0, 0, 32'h0, 0);
      acc(0, 12'h3F4, 0, 32'h0, 1);
      acc(1, 12'h800, 32'hFF, 0, 1);
      acc(0, REG_STATUS, 0, 32'h30, 0);
      acc(1, REG_STATUS, 32'h3F, 0, 0);
      acc(1, REG_ENABLE, 32'h30, 0, 0);
      acc(0, REG_ENABLE, 0, 32'h30, 0);
      repeat (3) @(posedge clk);
      check("irq", 32'(irq), 32'h1);
      acc(1, REG_CLEAR, 32'h30, 0, 0);
      acc(0, REG_CLEAR, 0, 32'h0, 0);
      acc(0, REG_STATUS, 0, 32'h0, 0);
      check("irq", 32'(irq), 32'h0);
      acc(1, 12'h014, 32'hFFFFFF3C, 0, 0);
      repeat (3) @(posedge clk);
      check("out_en", 32'(out_en), 32'h3C);
      acc(0, 12'h014, 0, 32'h3C, 0);
      pin_val <= 6'h04;
      settle();
      check("out_en", 32'(out_en), 32'h3D);
      pin_val <= 6'h00;
      settle();
      check("out_en", 32'(out_en), 32'h3C);
      acc(1, 12'h394, 32'h01, 0, 0);
      acc(1, REG_ENABLE, 32'h0F, 0, 0);
      repeat (3) @(posedge clk);
      check("oe", 32'(gpio_oe), 32'h20);
      for (int r = 0; r < 4; r++)
      begin
         // Bit 7 set to show only bits 6:0 select
         acc(1, 12'((CFG_GPIO_BASE_IDX + r) * 4), 32'h90 + 32'(4 * r), 0, 0);
         pin_val <= 6'(1 << r);
         settle();
         check("ref_los", 32'(ref_los), 32'(1 << r));
         check("irq_pin", 32'(gpio_out[5]), 32'h1);
         acc(0, REG_STATUS, 0, 32'(1 << r), 0);
         pin_val <= 6'h00;
         settle();
         check("ref_los", 32'(ref_los), 32'h0);
         acc(1, REG_CLEAR, 32'h0F, 0, 0);
         acc(1, 12'((CFG_GPIO_BASE_IDX + r) * 4), 32'h0, 0, 0);
         pin_val <= 6'(1 << r);
         settle();
         check("ref_los", 32'(ref_los), 32'h0);
         check("irq", 32'({gpio_out[5], irq}), 32'h0);
         check("oe", 32'(gpio_oe), 32'h20);
         pin_val <= 6'h00;
      end
      check("strap", 32'(strap), 32'h2A);
      for (int k = 0; k < 4; k++)
      begin
         do_reset(1'b1, 6'h28 | 6'(k));
         check("mclk", 32'({mclk_rsvd, mclk_sel}), 32'(k) | (k < 2 ? 32'h4 : 32'h0));
         acc(0, 12'(4 * (7 + k * 60)), 0, 32'(8'(7 + k * 60) ^ 8'hA5), 0);
      end
      summarize();
   end
endmodule
